// >>> rtl/apio_pkg.sv
// shared constants, carrier types and helper functions for the axi protection / id ordering slave
package apio_pkg;

	// ****************************************
	// port widths
	// ****************************************
	localparam int ID_W = 8;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int PROT_W = 3;
	localparam int CACHE_W = 4;
	localparam int RESP_W = 2;

	// ****************************************
	// field positions and encodings
	// ****************************************
	localparam int PROT_PRIV_BIT = 0;
	localparam int PROT_NONSEC_BIT = 1;
	localparam int PROT_INSTR_BIT = 2;
	localparam int CACHE_BUF_BIT = 0;
	localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
	localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
	// set to 1'b1 for the older port variant that carries an id on write data
	localparam logic AXI3_VARIANT = 1'b0;

	// ****************************************
	// storage sizes
	// ****************************************
	localparam int MEM_DEPTH = 16;
	localparam int MEM_IDX_W = 4;
	localparam int WORD_LSB = 2;
	localparam int PBUF_DEPTH = 4;
	localparam int PBUF_PTR_W = 2;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int DRAIN_PERIOD_NS = 20;
	// longest time, so round down, never below one cycle
	localparam int DRAIN_CYC_RAW = (DRAIN_PERIOD_NS * 1000) / CLK_PERIOD_PS;
	localparam int DRAIN_CYC = (DRAIN_CYC_RAW < 1) ? 1 : DRAIN_CYC_RAW;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic [ID_W-1:0] id;
		logic [ADDR_W-1:0] addr;
		logic [PROT_W-1:0] prot;
		logic [CACHE_W-1:0] cache;
	} apio_addr_t;

	typedef struct packed {
		logic priv;
		logic nonsec;
		logic instr;
	} apio_prot_t;

	typedef struct packed {
		logic [MEM_IDX_W-1:0] idx;
		logic [DATA_W-1:0] data;
	} apio_post_t;

	// ****************************************
	// functions
	// ****************************************
	// word index of an address inside the local store
	function automatic logic [MEM_IDX_W-1:0] apio_word_idx(input logic [ADDR_W-1:0] a);
		return a[WORD_LSB +: MEM_IDX_W];
	endfunction

	// split the three protection bits into named attributes
	function automatic apio_prot_t apio_prot_decode(input logic [PROT_W-1:0] p);
		apio_prot_t r;
		r.priv = p[PROT_PRIV_BIT];
		r.nonsec = p[PROT_NONSEC_BIT];
		r.instr = p[PROT_INSTR_BIT];
		return r;
	endfunction

endpackage

// >>> rtl/apio_prot_chk.sv
// protection attribute decode and access permission check
module apio_prot_chk import apio_pkg::*; (
	input wire logic [PROT_W-1:0] prot,
	input wire logic secure_only,
	input wire logic priv_only,
	output apio_prot_t attr,
	output logic permit
);

	// ****************************************
	// decode and check
	// ****************************************
	// the instruction bit is a hint only, so it never takes part in the decision
	always_comb begin
		attr = apio_prot_decode(prot);
		permit = 1'b1;
		if (priv_only && !attr.priv) begin
			permit = 1'b0;
		end
		if (secure_only && attr.nonsec) begin
			permit = 1'b0;
		end
	end

endmodule

// >>> rtl/apio_post_buf.sv
// posted write buffer that drains buffered writes to the final store at a steady rate
module apio_post_buf import apio_pkg::*; (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input apio_post_t in_data,
	output logic drain_we,
	output apio_post_t drain_data,
	output logic empty
);

	localparam int DRAIN_LIM = 8;

	apio_post_t slot_q [PBUF_DEPTH];
	logic [PBUF_PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [PBUF_PTR_W:0] count_q, count_d;
	logic [PBUF_PTR_W:0] div_q, div_d;
	logic tick, push;

	// ****************************************
	// drain divider and pointers
	// ****************************************
	// the divider runs free so a drain never waits longer than one period
	always_comb begin
		tick = (div_q == (PBUF_PTR_W+1)'(DRAIN_CYC - 1));
		div_d = tick ? '0 : div_q + (PBUF_PTR_W+1)'(1);
		empty = (count_q == '0);
		in_ready = (count_q != (PBUF_PTR_W+1)'(PBUF_DEPTH));
		push = in_valid && in_ready;
		drain_we = tick && !empty;
		drain_data = slot_q[rd_ptr_q];
		wr_ptr_d = push ? wr_ptr_q + PBUF_PTR_W'(1) : wr_ptr_q;
		rd_ptr_d = drain_we ? rd_ptr_q + PBUF_PTR_W'(1) : rd_ptr_q;
		count_d = count_q + (PBUF_PTR_W+1)'(push) - (PBUF_PTR_W+1)'(drain_we);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			div_q <= '0;
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			div_q <= div_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
		end
	end

	// slots need no reset, they are only read behind the count
	always_ff @(posedge clock) begin
		if (push) begin
			slot_q[wr_ptr_q] <= in_data;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_drain_timely: assert property (@(posedge clock) disable iff (!resetn)
		!empty |-> ##[0:DRAIN_LIM] drain_we)
		else $error("posted write not drained in time");

	// a push with no drain must grow the count by exactly one, or a post would be lost
	a_buf_bounds: assert property (@(posedge clock) disable iff (!resetn)
		(push && !drain_we) |=> count_q == $past(count_q) + (PBUF_PTR_W+1)'(1))
		else $error("posted buffer count lost an entry");

endmodule

// >>> rtl/apio_slave.sv
// axi slave that decodes protection bits, echoes ids and keeps same-id traffic in order
module apio_slave import apio_pkg::*; (
	input wire logic clock,
	input wire logic resetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ID_W-1:0] awid,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [PROT_W-1:0] awprot,
	input wire logic [CACHE_W-1:0] awcache,
	input wire logic wvalid,
	output logic wready,
	input wire logic [ID_W-1:0] wid,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wlast,
	output logic bvalid,
	input wire logic bready,
	output logic [ID_W-1:0] bid,
	output logic [RESP_W-1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ID_W-1:0] arid,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [PROT_W-1:0] arprot,
	input wire logic [CACHE_W-1:0] arcache,
	output logic rvalid,
	input wire logic rready,
	output logic [ID_W-1:0] rid,
	output logic [DATA_W-1:0] rdata,
	output logic [RESP_W-1:0] rresp,
	output logic rlast,
	input wire logic secure_only,
	input wire logic priv_only,
	output apio_prot_t access_attr,
	output logic access_denied
);

	typedef enum logic [2:0] {ST_IDLE, ST_WDATA, ST_CHECK, ST_COMMIT, ST_RESP} apio_state_t;

	apio_state_t state_q, state_d;
	apio_addr_t txn_q, txn_d;
	logic is_wr_q, is_wr_d;
	logic rd_turn_q, rd_turn_d;
	logic awready_q, awready_d, arready_q, arready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [ID_W-1:0] bid_q, bid_d, rid_q, rid_d;
	logic [RESP_W-1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DATA_W-1:0] rdata_q, rdata_d, wdata_q, wdata_d;
	apio_prot_t attr_q, attr_d, attr_c;
	logic denied_q, denied_d;
	logic permit, wid_ok, mem_we_dir, push_valid;
	logic pbuf_ready, pbuf_empty, drain_we;
	apio_post_t push_data, drain_data;
	logic [MEM_IDX_W-1:0] idx;
	logic [DATA_W-1:0] mem_q [MEM_DEPTH];

	// ****************************************
	// helpers
	// ****************************************
	apio_prot_chk u_prot (
		.prot(txn_q.prot),
		.secure_only(secure_only),
		.priv_only(priv_only),
		.attr(attr_c),
		.permit(permit)
	);

	apio_post_buf u_post (
		.clock(clock),
		.resetn(resetn),
		.in_valid(push_valid),
		.in_ready(pbuf_ready),
		.in_data(push_data),
		.drain_we(drain_we),
		.drain_data(drain_data),
		.empty(pbuf_empty)
	);

	// write data id is only compared in the older variant; otherwise the port is ignored
	assign wid_ok = !AXI3_VARIANT || (wid == txn_q.id);
	assign idx = apio_word_idx(txn_q.addr);
	assign push_data = '{idx: idx, data: wdata_q};

	// ****************************************
	// transaction sequencer
	// ****************************************
	// one transaction at a time keeps every same-id stream in issue order
	// at the cost of no overlap; different ids simply queue behind each other
	always_comb begin
		state_d = state_q;
		txn_d = txn_q;
		is_wr_d = is_wr_q;
		rd_turn_d = rd_turn_q;
		awready_d = awready_q;
		arready_d = arready_q;
		wready_d = wready_q;
		bvalid_d = bvalid_q;
		rvalid_d = rvalid_q;
		bid_d = bid_q;
		rid_d = rid_q;
		bresp_d = bresp_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		wdata_d = wdata_q;
		attr_d = attr_q;
		denied_d = 1'b0;
		mem_we_dir = 1'b0;
		push_valid = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (awready_q && awvalid) begin
					txn_d = '{id: awid, addr: awaddr, prot: awprot, cache: awcache};
					is_wr_d = 1'b1;
					awready_d = 1'b0;
					arready_d = 1'b0;
					wready_d = 1'b1;
					state_d = ST_WDATA;
				end else if (arready_q && arvalid) begin
					txn_d = '{id: arid, addr: araddr, prot: arprot, cache: arcache};
					is_wr_d = 1'b0;
					awready_d = 1'b0;
					arready_d = 1'b0;
					state_d = ST_CHECK;
				end else begin
					// alternate offers so neither channel starves
					rd_turn_d = !rd_turn_q;
					awready_d = rd_turn_q;
					arready_d = !rd_turn_q;
				end
			end
			ST_WDATA: begin
				if (wvalid && wid_ok) begin
					wdata_d = wdata;
					wready_d = 1'b0;
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				attr_d = attr_c;
				if (!permit) begin
					denied_d = 1'b1;
					state_d = ST_RESP;
					if (is_wr_q) begin
						bvalid_d = 1'b1;
						bid_d = txn_q.id;
						bresp_d = RESP_SLVERR;
					end else begin
						rvalid_d = 1'b1;
						rid_d = txn_q.id;
						rresp_d = RESP_SLVERR;
						rdata_d = '0;
					end
				end else begin
					state_d = ST_COMMIT;
				end
			end
			ST_COMMIT: begin
				if (is_wr_q && txn_q.cache[CACHE_BUF_BIT]) begin
					// buffered write: answer as soon as the buffer holds it
					push_valid = 1'b1;
					if (pbuf_ready) begin
						bvalid_d = 1'b1;
						bid_d = txn_q.id;
						bresp_d = RESP_OKAY;
						state_d = ST_RESP;
					end
				end else if (pbuf_empty) begin
					// unbuffered access goes to the store only after earlier posts land
					state_d = ST_RESP;
					if (is_wr_q) begin
						mem_we_dir = 1'b1;
						bvalid_d = 1'b1;
						bid_d = txn_q.id;
						bresp_d = RESP_OKAY;
					end else begin
						rvalid_d = 1'b1;
						rid_d = txn_q.id;
						rresp_d = RESP_OKAY;
						rdata_d = mem_q[idx];
					end
				end
			end
			ST_RESP: begin
				if ((bvalid_q && bready) || (rvalid_q && rready)) begin
					bvalid_d = 1'b0;
					rvalid_d = 1'b0;
					rd_turn_d = !rd_turn_q;
					awready_d = rd_turn_q;
					arready_d = !rd_turn_q;
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			txn_q <= '0;
			is_wr_q <= 1'b0;
			rd_turn_q <= 1'b0;
			awready_q <= 1'b0;
			arready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			bid_q <= '0;
			rid_q <= '0;
			bresp_q <= RESP_OKAY;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			wdata_q <= '0;
			attr_q <= '0;
			denied_q <= 1'b0;
		end else begin
			state_q <= state_d;
			txn_q <= txn_d;
			is_wr_q <= is_wr_d;
			rd_turn_q <= rd_turn_d;
			awready_q <= awready_d;
			arready_q <= arready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			rvalid_q <= rvalid_d;
			bid_q <= bid_d;
			rid_q <= rid_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			wdata_q <= wdata_d;
			attr_q <= attr_d;
			denied_q <= denied_d;
		end
	end

	// ****************************************
	// final store
	// ****************************************
	// drains and direct writes never collide: a direct write waits for an empty buffer
	always_ff @(posedge clock) begin
		if (drain_we) begin
			mem_q[drain_data.idx] <= drain_data.data;
		end else if (mem_we_dir) begin
			mem_q[idx] <= wdata_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign awready = awready_q;
	assign arready = arready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bid = bid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rid = rid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign rlast = rvalid_q; // single-beat only
	assign access_attr = attr_q;
	assign access_denied = denied_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_bresp_issued;
		$rose(bvalid_q);
	endsequence

	sequence s_rresp_issued;
		$rose(rvalid_q);
	endsequence

	a_bid_echo: assert property (s_bresp_issued |-> bid_q == txn_q.id)
		else $error("write response id differs from request id");

	a_rid_echo: assert property (s_rresp_issued |-> rid_q == txn_q.id && rlast)
		else $error("read response id differs from request id");

	a_nonbuf_drained: assert property (
		s_bresp_issued ##0 (!txn_q.cache[CACHE_BUF_BIT] && bresp_q == RESP_OKAY) |-> pbuf_empty)
		else $error("unbuffered write answered before posts drained");

	a_single_outstanding: assert property (
		(state_q != ST_IDLE) |-> !awready_q && !arready_q && !(bvalid_q && rvalid_q))
		else $error("new request offered while one is open");

	a_resp_hold: assert property (
		bvalid_q && !bready |=> bvalid_q && $stable(bid_q) && $stable(bresp_q))
		else $error("write response dropped before handshake");

	a_priv_denied: assert property (
		s_bresp_issued ##0 (priv_only && !txn_q.prot[PROT_PRIV_BIT]) |-> bresp_q == RESP_SLVERR)
		else $error("unprivileged write allowed under privileged-only policy");

	a_nonsec_denied: assert property (
		s_rresp_issued ##0 (secure_only && txn_q.prot[PROT_NONSEC_BIT]) |-> rresp_q == RESP_SLVERR)
		else $error("non-secure read allowed under secure-only policy");

	a_instr_hint: assert property (
		(state_q == ST_CHECK) |=> attr_q.instr == txn_q.prot[PROT_INSTR_BIT] && denied_q == !permit)
		else $error("instruction hint captured wrongly");

	a_wid_match: assert property (
		(state_q == ST_WDATA && wvalid && AXI3_VARIANT && wid != txn_q.id) |=> state_q == ST_WDATA)
		else $error("write data taken with foreign id");

endmodule

// >>> sim/apio_master.sv
// master-side model that issues single-beat writes and reads into the slave
module apio_master import apio_pkg::*; (
	input wire logic clock,
	output logic awvalid,
	input wire logic awready,
	output apio_addr_t aw,
	output logic wvalid,
	input wire logic wready,
	output logic [DATA_W-1:0] wdata,
	input wire logic bvalid,
	output logic bready,
	output logic arvalid,
	input wire logic arready,
	output apio_addr_t ar,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// idle levels
	// ****************************************
	// released buses carry the inverse of their last value, never a stale copy
	initial begin
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b0;
		rready = 1'b0;
		aw = '0;
		ar = '0;
		wdata = '0;
	end

	// ****************************************
	// transfers
	// ****************************************
	// wait for the answer, then accept it after stall cycles (0 = prompt)
	task automatic respond(input logic rd, input int stall);
		do @(negedge clock); while (!(rd ? rvalid : bvalid));
		repeat (stall) @(posedge clock);
		@(posedge clock);
		if (rd) bready <= 1'b0;
		if (rd) rready <= 1'b1;
		else bready <= 1'b1;
		@(posedge clock);
		rready <= 1'b0;
		bready <= 1'b0;
	endtask

	// one write at a time: nothing new until its response is taken
	task automatic write(input apio_addr_t a, input logic [DATA_W-1:0] d, input int stall);
		logic pa;
		logic pw;
		logic ta;
		logic tw;
		pa = 1'b1;
		pw = 1'b1;
		aw <= a; // three protection bits ride with every address
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1; // data offered before the address is taken
		while (pa || pw) begin
			@(negedge clock);
			ta = pa && awready;
			tw = pw && wready;
			@(posedge clock);
			if (ta) begin
				awvalid <= 1'b0;
				aw <= ~a;
				pa = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				wdata <= ~d;
				pw = 1'b0;
			end
		end
		respond(1'b0, stall);
	endtask

	// single read, address held until the ready edge
	task automatic read(input apio_addr_t a, input int stall);
		logic ta;
		ar <= a;
		arvalid <= 1'b1;
		ta = 1'b0;
		while (!ta) begin
			@(negedge clock);
			ta = arready;
			@(posedge clock);
		end
		arvalid <= 1'b0;
		ar <= ~a;
		respond(1'b1, stall);
	endtask
endmodule

// >>> sim/apio_slave_tb_top.sv
// self-checking bench for the protection and id handling slave
module apio_slave_tb_top import apio_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic rd;
		logic [ID_W-1:0] id;
		logic [RESP_W-1:0] resp;
		logic [DATA_W-1:0] data;
		apio_prot_t attr;
	} apio_exp_t;

	logic clock = 1'b0;
	logic resetn;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, rlast;
	logic secure_only, priv_only, access_denied;
	logic [DATA_W-1:0] wdata, rdata;
	logic [ID_W-1:0] bid, rid;
	logic [RESP_W-1:0] bresp, rresp;
	apio_addr_t aw, ar;
	apio_prot_t access_attr;
	apio_exp_t q[$];
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	logic [15:0] rnd = 16'h005D;
	logic so = 1'b0;
	logic po = 1'b0;
	int n_fail = 0;
	int checked = 0;
	int n_den = 0;
	int n_den_exp = 0;

	always #2.5 clock = ~clock;

	// ****************************************
	// design and far-side model
	// ****************************************
	apio_slave u_apio_slave (.clock(clock), .resetn(resetn), .awvalid(awvalid), .awready(awready),
		.awid(aw.id), .awaddr(aw.addr), .awprot(aw.prot), .awcache(aw.cache), .wvalid(wvalid),
		.wready(wready), .wid(aw.id), .wdata(wdata), .wlast(1'b1), .bvalid(bvalid), .bready(bready),
		.bid(bid), .bresp(bresp), .arvalid(arvalid), .arready(arready), .arid(ar.id), .araddr(ar.addr),
		.arprot(ar.prot), .arcache(ar.cache), .rvalid(rvalid), .rready(rready), .rid(rid), .rdata(rdata),
		.rresp(rresp), .rlast(rlast), .secure_only(secure_only), .priv_only(priv_only),
		.access_attr(access_attr), .access_denied(access_denied));

	apio_master u_apio_master (.clock(clock), .awvalid(awvalid), .awready(awready), .aw(aw),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
		.arvalid(arvalid), .arready(arready), .ar(ar), .rvalid(rvalid), .rready(rready));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] nxt(input logic [15:0] r);
		return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
	endfunction

	task automatic one(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		if (n_fail == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// a missing note pops as all ones so it can never match
	task automatic cmp_b();
		apio_exp_t e;
		e = (q.size() == 0) ? '1 : q.pop_front();
		one(64'({1'b0, bid, bresp, access_attr}), 64'({e.rd, e.id, e.resp, e.attr}));
	endtask

	task automatic cmp_r();
		apio_exp_t e;
		e = (q.size() == 0) ? '0 : q.pop_front();
		one(64'({1'b1, rid, rresp, access_attr, rlast}), 64'({e.rd, e.id, e.resp, e.attr, 1'b1}));
		one(64'(rdata), 64'(e.data));
	endtask

	// expected answer worked out from the policy levels and the protection bits
	task automatic xact(input logic rd, input logic [MEM_IDX_W-1:0] ix, input logic [PROT_W-1:0] p,
		input logic posted);
		apio_addr_t a;
		apio_exp_t e;
		logic den;
		rnd = nxt(rnd);
		a.id = rnd[15:8];
		a.addr = {rnd[7:2], 20'h00000, ix, 2'h0};
		a.prot = p; // instruction hint set only where the scenario asks for it
		a.cache = {rnd[3:1], posted};
		den = (so && p[PROT_NONSEC_BIT]) || (po && !p[PROT_PRIV_BIT]);
		rnd = nxt(rnd);
		e.rd = rd;
		e.id = a.id;
		e.resp = den ? RESP_SLVERR : RESP_OKAY;
		e.attr = {p[0], p[1], p[2]};
		e.data = (rd && !den) ? mem[ix] : '0;
		n_den_exp += int'(den);
		q.push_back(e);
		if (rd) begin
			u_apio_master.read(a, int'(rnd[1:0]));
		end else begin
			if (!den) mem[ix] = {rnd, ~rnd};
			u_apio_master.write(a, {rnd, ~rnd}, int'(rnd[1:0]));
		end
	endtask

	// ****************************************
	// result watcher
	// ****************************************
	// sampled mid-cycle, the edge after a seen valid+ready pair is the handshake
	always @(negedge clock) begin
		if (bvalid === 1'b1 && bready === 1'b1) cmp_b();
		if (rvalid === 1'b1 && rready === 1'b1) cmp_r();
		if (access_denied === 1'b1) n_den++;
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		resetn = 1'b0;
		secure_only = 1'b0;
		priv_only = 1'b0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		// every fifth write is unposted; its answer is trusted only for earlier posts to this slave
		for (int i = 0; i < 16; i++) xact(1'b0, 4'(i), 3'(i), (i % 5) != 4);
		for (int i = 0; i < 16; i++) xact(1'b1, 4'(i), 3'(i), 1'b0);
		// every policy against every protection code, each write followed by a read of a random word
		for (int k = 0; k < 32; k++) begin
			so = k[4];
			po = k[3];
			secure_only <= so;
			priv_only <= po;
			@(posedge clock);
			xact(1'b0, rnd[5:2], 3'(k), rnd[6]);
			xact(1'b1, rnd[7:4], 3'(k), 1'b0);
		end
		repeat (10) @(posedge clock);
		one(64'(n_den), 64'(n_den_exp));
		one(64'(q.size()), 64'h0000000000000000);
		conclude();
	end

	// the whole run needs under two thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		conclude();
	end
endmodule
